// File: cbt_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

// Register byte addresses
`define CBT_OFS_CFG2       12'h000
`define CBT_OFS_WORD2      12'h004
`define CBT_OFS_WORD3      12'h008

// Bit timing configuration fields
`define CBT_CFG2_WAKE_BIT  14
`define CBT_CFG2_PH2_LSB   8
`define CBT_CFG2_PH2SEL    7
`define CBT_CFG2_TRI_BIT   6
`define CBT_CFG2_PH1_LSB   3
`define CBT_CFG2_PROP_LSB  0
`define CBT_CFG2_WMASK     16'h47FF

// Message buffer word 2 fields
`define CBT_W2_RTR_BIT     9
`define CBT_W2_RSVH_BIT    8
`define CBT_W2_RSVL_BIT    4
`define CBT_W2_DLC_LSB     0
`define CBT_W2_WMASK       16'hFF1F

// Message buffer word 3 fields
`define CBT_W3_BYTE1_LSB   8
`define CBT_W3_BYTE0_LSB   0

// Reset values
`define CBT_RST_CFG2       16'h0000
`define CBT_RST_WORD2      16'h0000
`define CBT_RST_WORD3      16'h0000

// Timing counts in pclk cycles and time quanta
`define CBT_TQ_DIV         8'h04
`define CBT_PROC_TQ        4'h2
`define CBT_FILT_CYC       4'h4

`endif

// File: cbt_pkg.sv
// Types shared by the bit timing and message buffer block
package cbt_pkg;
   // Segment of the nominal bit time
   typedef enum logic [1:0] {
      SEG_SYNC,
      SEG_PROP,
      SEG_PH1,
      SEG_PH2
   } cbt_seg_type;
endpackage

// File: cbt_top.sv
// CAN bit timing engine and message buffer words 2 and 3 behind an APB slave
//
// Overview of operation
// - Wake filter select routes glitch filter to wake
// - Phase 2 length is field plus one
// - Select: programmed phase 2, else max(ph1, processing)
// - Extended frame: remote bit makes remote request
// - Standard frame ignores the remote bit
// - Data length code sits in word 2 bits 3:0
// - Second data byte in word 3 upper byte
// - First data byte in word 3 lower byte
// - Word 2 bits 7:5 read as zero
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defines.svh"

module cbt_top (
   input  wire logic        pclk,           // 250 MHz clock
   input  wire logic        presetn,        // Async reset, active low
   input  wire logic        ce,             // Clock enable, freezes all state when low
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB access phase
   input  wire logic        pwrite,         // APB direction
   input  wire logic [11:0] paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   input  wire logic [3:0]  pstrb,          // APB byte strobes
   output logic      [31:0] prdata,         // APB read data
   output logic             pready,         // APB ready
   output logic             pslverr,        // APB error on unmapped address
   input  wire logic        can_rx,         // Bus line, 0 is dominant
   input  wire logic        ide_flag,       // Extended identifier flag of the message
   output logic             sample_point,   // Pulse at the sample point
   output logic             rx_bit,         // Bit value taken at the sample point
   output logic             bit_end,        // Pulse at the end of each bit time
   output logic             wake_event,     // Pulse on a dominant edge seen by wake logic
   output logic             remote_frame,   // Message is a remote request
   output logic      [3:0]  data_len,       // Data length code
   output logic      [7:0]  data_byte0,     // First data byte
   output logic      [7:0]  data_byte1      // Second data byte
);

   // Register storage
   logic [15:0] cfg_q, cfg_d;               // Bit timing configuration
   logic [15:0] w2_q, w2_d;                 // Buffer word 2
   logic [15:0] w3_q, w3_d;                 // Buffer word 3
   logic [31:0] prdata_q, prdata_d;         // Registered read data
   logic        pready_q, pready_d;         // Registered ready
   logic        pslverr_q, pslverr_d;       // Registered error
   logic        remote_q, remote_d;         // Registered frame type

   // Bus decode helpers
   logic        acc_first;                  // First access cycle, answer built here
   logic        acc_done;                   // Completing edge of the transfer
   logic        hit_cfg, hit_w2, hit_w3;    // Address matches
   logic [15:0] wmask;                      // Byte lanes that the write touches

   // Decode: one wait state so read data and ready leave flip-flops
   always_comb begin
      acc_first = psel & penable & ~pready_q;
      acc_done  = psel & penable & pready_q;
      hit_cfg   = (paddr == `CBT_OFS_CFG2);
      hit_w2    = (paddr == `CBT_OFS_WORD2);
      hit_w3    = (paddr == `CBT_OFS_WORD3);
      wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   end

   // Register file next state
   always_comb begin
      cfg_d     = cfg_q;
      w2_d      = w2_q;
      w3_d      = w3_q;
      prdata_d  = prdata_q;
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      if (acc_first) begin
         // Answer one cycle into the access phase
         pready_d  = 1'b1;
         pslverr_d = ~(hit_cfg | hit_w2 | hit_w3);
         if (hit_cfg) begin
            prdata_d = {16'h0000, cfg_q};
         end else if (hit_w2) begin
            // Bits 7:5 are held at zero in storage
            prdata_d = {16'h0000, w2_q};
         end else if (hit_w3) begin
            prdata_d = {16'h0000, w3_q};
         end else begin
            prdata_d = 32'h00000000;
         end
      end
      if (acc_done & pwrite) begin
         // Write lands only on the completing edge
         if (hit_cfg) begin
            cfg_d = (cfg_q & ~(wmask & `CBT_CFG2_WMASK))
                  | (pwdata[15:0] & wmask & `CBT_CFG2_WMASK);
         end
         if (hit_w2) begin
            // Reserved bits are stored as written; software keeps them zero
            w2_d = (w2_q & ~(wmask & `CBT_W2_WMASK))
                 | (pwdata[15:0] & wmask & `CBT_W2_WMASK);
         end
         if (hit_w3) begin
            w3_d = (w3_q & ~wmask) | (pwdata[15:0] & wmask);
         end
      end
   end

   // Frame type: remote bit counts only for extended messages
   always_comb begin
      remote_d = ide_flag & w2_q[`CBT_W2_RTR_BIT];
   end

   // Register file flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q     <= `CBT_RST_CFG2;
         w2_q      <= `CBT_RST_WORD2;
         w3_q      <= `CBT_RST_WORD3;
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         remote_q  <= 1'b0;
      end else if (ce) begin
         cfg_q     <= cfg_d;
         w2_q      <= w2_d;
         w3_q      <= w3_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         remote_q  <= remote_d;
      end
   end

   // Configuration fields
   logic       wake_sel;                    // Glitch filter on wake path
   logic       ph2_sel;                     // Phase 2 freely programmable
   logic       tri_sel;                     // Triple sampling
   logic [3:0] prop_len;                    // Propagation length in quanta
   logic [3:0] ph1_len;                     // Phase 1 length in quanta
   logic [3:0] ph2_prog;                    // Programmed phase 2 length
   logic [3:0] ph2_len;                     // Effective phase 2 length

   // Segment lengths in time quanta
   always_comb begin
      wake_sel = cfg_q[`CBT_CFG2_WAKE_BIT];
      ph2_sel  = cfg_q[`CBT_CFG2_PH2SEL];
      tri_sel  = cfg_q[`CBT_CFG2_TRI_BIT];
      prop_len = {1'b0, cfg_q[`CBT_CFG2_PROP_LSB +: 3]} + 4'h1;
      ph1_len  = {1'b0, cfg_q[`CBT_CFG2_PH1_LSB +: 3]} + 4'h1;
      ph2_prog = {1'b0, cfg_q[`CBT_CFG2_PH2_LSB +: 3]} + 4'h1;
      if (ph2_sel) begin
         ph2_len = ph2_prog;
      end else if (ph1_len > `CBT_PROC_TQ) begin
         ph2_len = ph1_len;
      end else begin
         ph2_len = `CBT_PROC_TQ;
      end
   end

   // Bit timing state
   cbt_pkg::cbt_seg_type seg_q, seg_d;      // Current segment
   logic [7:0] div_q, div_d;                // Quantum prescaler
   logic [3:0] left_q, left_d;              // Quanta left in segment minus one
   logic [2:0] hist_q, hist_d;              // Bus samples, one per quantum
   logic       rxb_q, rxb_d;                // Sampled bit
   logic       sp_q, sp_d;                  // Sample point pulse
   logic       be_q, be_d;                  // Bit end pulse
   logic       tick;                        // One pclk per time quantum
   logic [2:0] hist_n;                      // History including this quantum

   // Segment sequencer; no resynchronisation, the bit time is nominal only
   always_comb begin
      tick   = (div_q == 8'h00);
      div_d  = tick ? (`CBT_TQ_DIV - 8'h01) : (div_q - 8'h01);
      seg_d  = seg_q;
      left_d = left_q;
      hist_n = {hist_q[1:0], can_rx};
      hist_d = hist_q;
      rxb_d  = rxb_q;
      sp_d   = 1'b0;
      be_d   = 1'b0;
      if (tick) begin
         hist_d = hist_n;
         if (left_q != 4'h0) begin
            left_d = left_q - 4'h1;
         end else begin
            unique case (seg_q)
               cbt_pkg::SEG_SYNC: begin
                  seg_d  = cbt_pkg::SEG_PROP;
                  left_d = prop_len - 4'h1;
               end
               cbt_pkg::SEG_PROP: begin
                  seg_d  = cbt_pkg::SEG_PH1;
                  left_d = ph1_len - 4'h1;
               end
               cbt_pkg::SEG_PH1: begin
                  // Sample point closes phase 1
                  seg_d  = cbt_pkg::SEG_PH2;
                  left_d = ph2_len - 4'h1;
                  sp_d   = 1'b1;
                  if (tri_sel) begin
                     // Majority of the last three quanta
                     rxb_d = (hist_n[0] & hist_n[1]) | (hist_n[0] & hist_n[2])
                           | (hist_n[1] & hist_n[2]);
                  end else begin
                     rxb_d = can_rx;
                  end
               end
               cbt_pkg::SEG_PH2: begin
                  seg_d  = cbt_pkg::SEG_SYNC;
                  left_d = 4'h0;
                  be_d   = 1'b1;
               end
            endcase
         end
      end
   end

   // Bit timing flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seg_q  <= cbt_pkg::SEG_SYNC;
         div_q  <= 8'h00;
         left_q <= 4'h0;
         hist_q <= 3'h7;
         rxb_q  <= 1'b1;
         sp_q   <= 1'b0;
         be_q   <= 1'b0;
      end else if (ce) begin
         seg_q  <= seg_d;
         div_q  <= div_d;
         left_q <= left_d;
         hist_q <= hist_d;
         rxb_q  <= rxb_d;
         sp_q   <= sp_d;
         be_q   <= be_d;
      end
   end

   // Wake path state
   logic       filt_q, filt_d;              // Filtered bus level
   logic [3:0] fcnt_q, fcnt_d;              // Cycles the raw level differs
   logic       wprev_q, wprev_d;            // Previous wake source level
   logic       wake_q, wake_d;              // Wake pulse
   logic       wsrc;                        // Level seen by wake logic

   // Glitch filter: a level change must hold for a fixed run of cycles
   always_comb begin
      filt_d = filt_q;
      fcnt_d = 4'h0;
      if (can_rx != filt_q) begin
         if (fcnt_q == (`CBT_FILT_CYC - 4'h1)) begin
            filt_d = can_rx;
         end else begin
            fcnt_d = fcnt_q + 4'h1;
         end
      end
      // Unfiltered wake reacts faster but also to spikes
      wsrc    = wake_sel ? filt_q : can_rx;
      wprev_d = wsrc;
      wake_d  = wprev_q & ~wsrc;
   end

   // Wake path flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_q  <= 1'b1;
         fcnt_q  <= 4'h0;
         wprev_q <= 1'b1;
         wake_q  <= 1'b0;
      end else if (ce) begin
         filt_q  <= filt_d;
         fcnt_q  <= fcnt_d;
         wprev_q <= wprev_d;
         wake_q  <= wake_d;
      end
   end

   // Outputs straight from flip-flops
   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign sample_point = sp_q;
   assign rx_bit       = rxb_q;
   assign bit_end      = be_q;
   assign wake_event   = wake_q;
   assign remote_frame = remote_q;
   assign data_len     = w2_q[`CBT_W2_DLC_LSB +: 4];
   assign data_byte0   = w3_q[`CBT_W3_BYTE0_LSB +: 8];
   assign data_byte1   = w3_q[`CBT_W3_BYTE1_LSB +: 8];

endmodule

`default_nettype wire

// File: cbt_node.sv
// Behavioural model of another node driving the bus line
`timescale 1ns/1ps
`default_nettype none
module cbt_node (
   input  wire logic        pclk,      // Shared clock
   input  wire logic        presetn,   // Async reset, active low
   input  wire logic        bit_end,   // Bit boundary seen on the bus
   input  wire logic        run,       // Send the pattern when high
   input  wire logic [15:0] pattern,   // Bits sent, index 0 first
   input  wire logic [3:0]  pulse_len, // Dominant pulse length in cycles
   input  wire logic        pulse_go,  // Start a dominant pulse
   output logic             can_rx     // Bus line level, 0 dominant
);
   logic [3:0] idx_q; // Bit index in the pattern
   logic [3:0] len_q; // Pulse cycles left
   // A node in step with the bus changes level only at bit boundaries
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= 4'h0;
         len_q <= 4'h0;
      end else begin
         if (run && bit_end) idx_q <= idx_q + 4'h1;
         if (pulse_go) len_q <= pulse_len;
         else if (len_q != 4'h0) len_q <= len_q - 4'h1;
      end
   end
   // Idle bus is recessive; a pulse overrides the pattern
   assign can_rx = (len_q != 4'h0) ? 1'b0 : (run ? pattern[idx_q] : 1'b1);
endmodule
`default_nettype wire

// File: cbt_assertions.sv
// Port-level checker for the bit timing and message buffer block
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defines.svh"
module cbt_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ide_flag,
   input wire logic        sample_point,
   input wire logic        bit_end,
   input wire logic        remote_frame,
   input wire logic [3:0]  data_len,
   input wire logic [7:0]  data_byte0,
   input wire logic [7:0]  data_byte1
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wdone; // Write completing at this edge
   assign wdone = psel && penable && pready && pwrite;
   property p_rdy_one; pready |=> !pready; endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
   property p_wait; psel && penable && !pready && ce |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("ready not after one wait state");
   property p_err; pready |-> pslverr == !(paddr == `CBT_OFS_CFG2 || paddr == `CBT_OFS_WORD2 || paddr == `CBT_OFS_WORD3);
   endproperty
   a_err: assert property (p_err) else $error("error flag wrong for address");
   property p_unimpl; pready && !pwrite && paddr == `CBT_OFS_WORD2 |-> prdata[7:5] == 3'h0; endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero");
   property p_std; !ide_flag |=> !remote_frame; endproperty
   a_std: assert property (p_std) else $error("remote set on standard frame");
   property p_dlc; wdone && paddr == `CBT_OFS_WORD2 && pstrb[0] |=> ##1 data_len == $past(pwdata[3:0], 2);
   endproperty
   a_dlc: assert property (p_dlc) else $error("length code not stored");
   property p_b0; wdone && paddr == `CBT_OFS_WORD3 && pstrb[0] |=> ##1 data_byte0 == $past(pwdata[7:0], 2);
   endproperty
   a_b0: assert property (p_b0) else $error("first byte not stored");
   property p_b1; wdone && paddr == `CBT_OFS_WORD3 && pstrb[1] |=> ##1 data_byte1 == $past(pwdata[15:8], 2);
   endproperty
   a_b1: assert property (p_b1) else $error("second byte not stored");
   property p_ph2; sample_point |-> ##[4:32] bit_end; endproperty
   a_ph2: assert property (p_ph2) else $error("phase two out of range");
   property p_ph1; bit_end |-> ##[12:68] sample_point; endproperty
   a_ph1: assert property (p_ph1) else $error("phase one out of range");
   c_err: cover property (pready && pslverr);
   c_remote: cover property (remote_frame);
   c_bit: cover property (sample_point ##[4:32] bit_end);
endmodule
bind cbt_top cbt_checker cbt_checker_i (.*);
`default_nettype wire

// File: tb.sv
// Self-checking bench for the bit timing and message buffer block
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defines.svh"
module tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic [3:0]  pstrb = 4'h0, data_len, pulse_len = 4'h0;
   logic        pready, pslverr, can_rx, ide_flag = 1'b0, sample_point, rx_bit, bit_end, wake_event;
   logic        remote_frame, run = 1'b0, pulse_go = 1'b0, ce = 1'b1;
   logic [7:0]  data_byte0, data_byte1;
   logic [15:0] pattern = 16'hC3A5; // Mixed levels for sampling
   int          n_mismatch = 0, total_checks = 0, cyc = 0, fz = 0;
   // Rows: configuration, bit length and phase two length in quanta
   logic [15:0] cfg_t [5] = '{16'h0000, 16'h0787, 16'h0080, 16'h0738, 16'h0040};
   int          bq_t [5] = '{5, 18, 4, 18, 5};
   int          pq_t [5] = '{2, 8, 1, 8, 2};
   cbt_top  cbt_top_i (.*);
   cbt_node cbt_node_i (.*);
   initial begin
      forever #2 pclk = ~pclk;
   end
   // Hang guard, far beyond the expected run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // One APB transfer; request held until ready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait limit here: only the hang guard ends a missing answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, s, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic wait_be();
      do begin
         @(posedge pclk);
      end while (bit_end !== 1'b1);
   endtask
   // Count edges from one bit end to the sample point and on to the next bit end
   task automatic measure(input int bq, input int pq);
      int a, b;
      logic lv;
      wait_be();
      a = 0;
      do begin
         @(posedge pclk);
         a++;
      end while (sample_point !== 1'b1 && a < 200);
      lv = can_rx;
      b = 0;
      do begin
         @(posedge pclk);
         b++;
      end while (bit_end !== 1'b1 && b < 200);
      chk(32'(a + b), 32'(4 * bq));
      chk(32'(b), 32'(4 * pq));
      chk({31'h0, rx_bit}, {31'h0, lv});
   endtask
   // Dominant pulse on an idle bus, then count wake pulses
   task automatic pulse(input logic [3:0] l, input int x);
      int n;
      repeat (10) @(posedge pclk);
      pulse_len <= l;
      pulse_go <= 1'b1;
      @(posedge pclk);
      pulse_go <= 1'b0;
      n = 0;
      repeat (20) begin
         @(posedge pclk);
         n += int'(wake_event === 1'b1);
      end
      chk(32'(n), 32'(x));
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`CBT_OFS_CFG2, 32'h0, 1'b0);
      rd(`CBT_OFS_WORD2, 32'h0, 1'b0);
      rd(`CBT_OFS_WORD3, 32'h0, 1'b0);
      $display("test reset done");
      run <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr(`CBT_OFS_CFG2, {16'h0, cfg_t[i]}, 4'h3);
         repeat (3) wait_be();
         measure(bq_t[i], pq_t[i]);
         $display("test timing row %0d done", i);
      end
      wr(`CBT_OFS_CFG2, 32'hFFFF_FFFF, 4'hF);
      rd(`CBT_OFS_CFG2, 32'h47FF, 1'b0);
      // Reserved bits 8 and 4 written as zero, unimplemented 7:5 written as one
      wr(`CBT_OFS_WORD2, 32'hFFFF_FEEF, 4'hF);
      rd(`CBT_OFS_WORD2, 32'hFE0F, 1'b0);
      chk(32'(data_len), 32'hF);
      ide_flag <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({31'h0, remote_frame}, 32'h1);
      ide_flag <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({31'h0, remote_frame}, 32'h0);
      ide_flag <= 1'b1;
      wr(`CBT_OFS_WORD2, 32'h0000_0005, 4'h3);
      // Frame type is registered one cycle after the word changes
      @(posedge pclk);
      chk({31'h0, remote_frame}, 32'h0);
      chk(32'(data_len), 32'h5);
      wr(`CBT_OFS_WORD3, 32'h0000_A55A, 4'h3);
      chk({24'h0, data_byte1}, 32'hA5);
      chk({24'h0, data_byte0}, 32'h5A);
      wr(`CBT_OFS_WORD3, 32'h0000_1234, 4'h1);
      rd(`CBT_OFS_WORD3, 32'hA534, 1'b0);
      wr(12'h00C, 32'h0000_FFFF, 4'h3);
      rd(12'h00C, 32'h0, 1'b1);
      $display("test registers done");
      run <= 1'b0;
      wr(`CBT_OFS_CFG2, 32'h0, 4'h3);
      pulse(4'h2, 1);
      wr(`CBT_OFS_CFG2, 32'h4000, 4'h3);
      pulse(4'h2, 0);
      pulse(4'h8, 1);
      $display("test wake done");
      // Clock enable low for 8 cycles stretches the bit by exactly those cycles
      wait_be();
      ce <= 1'b0;
      repeat (8) @(posedge pclk);
      ce <= 1'b1;
      fz = 8;
      do begin
         @(posedge pclk);
         fz++;
      end while (sample_point !== 1'b1 && fz < 200);
      chk(32'(fz), 32'(4 * 3 + 8));
      $display("test clock enable done");
      // Reset in mid-run returns the buffer words to zero
      wr(`CBT_OFS_WORD3, 32'h0000_FFFF, 4'h3);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({24'h0, data_byte0}, 32'h0);
      chk(32'(data_len), 32'h0);
      rd(`CBT_OFS_WORD3, 32'h0, 1'b0);
      rd(`CBT_OFS_CFG2, 32'h0, 1'b0);
      $display("test mid-run reset done");
      complete_run();
   end
endmodule
`default_nettype wire
